// ==== hdl/thermal_status_pkg.sv ====
package thermal_status_pkg;
	localparam int ADDR_W = 7;
	localparam int SYNC_STAGES = 2;

	// Three-level strap encoding from the pin comparators
	localparam logic [1:0] STRAP_LOW = 2'h0;
	localparam logic [1:0] STRAP_FLOAT = 2'h1;
	localparam logic [1:0] STRAP_HIGH = 2'h2;
	localparam logic [3:0] STRAP_LEVELS = 4'h3;

	// Slave address per strap pair, index = a * 3 + b
	localparam logic [ADDR_W-1:0] ADDR_TABLE [0:8] = '{
		7'h18, 7'h19, 7'h1A,
		7'h29, 7'h2A, 7'h2B,
		7'h4C, 7'h4D, 7'h4E
	};
	localparam logic [ADDR_W-1:0] ALERT_RESP_ADDR = 7'h0C;
	localparam logic ALERT_RESP_LSB = 1'h1;

	// Power-up values
	localparam logic [7:0] CMD_PTR_POR = 8'h01;
	localparam logic [7:0] HIGH_LIMIT_POR = 8'h7F;
	localparam logic [7:0] LOW_LIMIT_POR = 8'hC9;

	// Status byte bit positions
	localparam int STAT_BUSY_BIT = 7;
	localparam int STAT_OVER_BIT = 4;
	localparam int STAT_UNDER_BIT = 3;
	localparam int STAT_FAULT_BIT = 2;

	typedef struct packed {
		logic busy;
		logic [1:0] reserved_hi;
		logic over_limit_flag;
		logic under_limit_flag;
		logic sensor_fault;
		logic [1:0] reserved_lo;
	} alarm_and_activity_flags_t;

	typedef struct packed {
		logic over_limit;
		logic under_limit;
		logic sensor_fault;
	} alarm_events_t;

	typedef enum logic [1:0] {
		MODE_LATCHED,
		MODE_THERMOSTAT
	} alert_mode_t;
endpackage

// ==== hdl/sticky_flag.sv ====
`timescale 1ns/100ps
module sticky_flag (
	input wire logic i_mclk,
	input wire logic i_srst,
	input wire logic i_set,
	input wire logic i_clr,
	output logic o_flag
);
	logic next_flag;

	// Set beats clear so an event landing on a clear is kept
	assign next_flag = i_set | (o_flag & ~i_clr);

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_flag <= 1'b0;
		end else begin
			o_flag <= next_flag;
		end
	end
endmodule

// ==== hdl/thermal_status_address_por.sv ====
`timescale 1ns/100ps
// What this block does
// [RQ1] Busy bit high while converting
// [RQ2] Bits 6,5,1,0 always read zero
// [RQ3] Over-limit alarm sets bit 4
// [RQ4] Thermostat mode: bit 4 mirrors alert pin
// [RQ5] Under-limit sets bit 3; zero in thermostat
// [RQ6] Sensor fault sets bit 2
// [RQ7] Latched mode alarms stick until read/reset
// [RQ8] Straps decode to one of nine addresses
// [RQ9] Straps sampled only during power-on reset
// [RQ10] Answer alert response address when interrupt pending
// [RQ11] Supply collapse clears all volatile state
// [RQ12] No conversions while supply lockout asserted
// [RQ13] Command pointer powers up at 01h
// [RQ14] Limits power up at max and min
// [RQ15] Power-up: interrupt latch clear, latched mode
// [RQ16] Host avoids access below 3V supply
// [RQ17] Alert response returns address, LSB one, clears latch
// [RQ18] Status read leaves interrupt latch alone
// [RQ19] Lower limit powers up at C9h
// [RQ20] Event during clearing read is kept
// [RQ21] Status captured at read start, held stable
module thermal_status_address_por (
	input wire logic i_mclk,
	input wire logic i_srst,
	input wire logic [1:0] i_addr_strap_a,
	input wire logic [1:0] i_addr_strap_b,
	input wire logic i_supply_lockout,
	input wire logic i_conv_active,
	input wire thermal_status_pkg::alarm_events_t i_events,
	input wire logic i_thermostat_sel,
	input wire logic i_alert_mask,
	input wire logic i_alert_pin_level,
	input wire logic i_status_rd_start,
	input wire logic i_status_rd_done,
	input wire logic i_ara_rd_done,
	input wire logic i_cmd_wr,
	input wire logic i_high_wr,
	input wire logic i_low_wr,
	input wire logic [7:0] i_wr_data,
	output thermal_status_pkg::alarm_and_activity_flags_t o_status,
	output logic [6:0] o_slave_addr,
	output logic o_ara_respond,
	output logic [7:0] o_ara_byte,
	output logic o_irq_pending,
	output logic o_conv_enable,
	output thermal_status_pkg::alert_mode_t o_mode,
	output logic [7:0] o_cmd_ptr,
	output logic [7:0] o_high_limit,
	output logic [7:0] o_low_limit
);
	import thermal_status_pkg::*;

	// Synchronisers: first stage is read only by the second
	logic [1:0] strap_a_meta;
	logic [1:0] strap_a_sync;
	logic [1:0] strap_b_meta;
	logic [1:0] strap_b_sync;
	logic lockout_meta;
	logic lockout_sync;

	always_ff @(posedge i_mclk) begin
		strap_a_meta <= i_addr_strap_a;
		strap_a_sync <= strap_a_meta;
		strap_b_meta <= i_addr_strap_b;
		strap_b_sync <= strap_b_meta;
		lockout_meta <= i_supply_lockout;
		lockout_sync <= lockout_meta;
	end

	// Strap decode; an illegal code is read as tied high
	wire [1:0] level_a = (strap_a_sync > STRAP_HIGH) ? STRAP_HIGH : strap_a_sync;
	wire [1:0] level_b = (strap_b_sync > STRAP_HIGH) ? STRAP_HIGH : strap_b_sync;
	wire [3:0] strap_index = 4'({2'h0, level_a}) * STRAP_LEVELS + 4'({2'h0, level_b}); // [RQ8]
	wire [6:0] decoded_addr = ADDR_TABLE[strap_index]; // [RQ8]

	// Latched only under reset: saves the float-detect bias afterwards
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_slave_addr <= decoded_addr; // [RQ9]
		end
	end

	wire thermo = (o_mode == MODE_THERMOSTAT);
	wire any_event = i_events.over_limit | i_events.under_limit | i_events.sensor_fault;

	// Alarm flags; reset is the supply-collapse clear
	logic over_flag;
	logic under_flag;
	logic fault_flag;
	logic irq_latch;

	sticky_flag u_over (
		.i_mclk(i_mclk),
		.i_srst(i_srst), // [RQ11]
		.i_set(i_events.over_limit & ~thermo), // [RQ3] [RQ20]
		.i_clr(i_status_rd_done | thermo), // [RQ7]
		.o_flag(over_flag)
	);

	sticky_flag u_under (
		.i_mclk(i_mclk),
		.i_srst(i_srst),
		.i_set(i_events.under_limit & ~thermo), // [RQ5] [RQ20]
		.i_clr(i_status_rd_done | thermo), // [RQ7]
		.o_flag(under_flag)
	);

	sticky_flag u_fault (
		.i_mclk(i_mclk),
		.i_srst(i_srst),
		.i_set(i_events.sensor_fault), // [RQ6] [RQ20]
		.i_clr(i_status_rd_done),
		.o_flag(fault_flag)
	);

	// Status read does not touch this latch
	sticky_flag u_irq (
		.i_mclk(i_mclk),
		.i_srst(i_srst), // [RQ15]
		.i_set(any_event & ~i_alert_mask & ~thermo),
		.i_clr(i_ara_rd_done), // [RQ17] [RQ18]
		.o_flag(irq_latch)
	);

	wire live_busy = i_conv_active & o_conv_enable; // [RQ1]
	wire live_over = thermo ? i_alert_pin_level : over_flag; // [RQ4]
	wire live_under = thermo ? 1'b0 : under_flag; // [RQ5]

	alarm_and_activity_flags_t live_status;
	assign live_status = '{
		busy: live_busy,
		reserved_hi: 2'h0, // [RQ2]
		over_limit_flag: live_over,
		under_limit_flag: live_under,
		sensor_fault: fault_flag,
		reserved_lo: 2'h0 // [RQ2]
	};

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_status <= '0;
		end else if (i_status_rd_start) begin
			o_status <= live_status; // [RQ21]
		end
	end

	// Converter gate follows the synchronised lockout
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_conv_enable <= 1'b0;
		end else begin
			o_conv_enable <= ~lockout_sync; // [RQ12]
		end
	end

	assign o_irq_pending = irq_latch;
	assign o_ara_respond = irq_latch; // [RQ10]
	assign o_ara_byte = {o_slave_addr, ALERT_RESP_LSB}; // [RQ17]

	// Volatile registers with power-up defaults
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_mode <= MODE_LATCHED; // [RQ15]
			o_cmd_ptr <= CMD_PTR_POR; // [RQ13]
			o_high_limit <= HIGH_LIMIT_POR; // [RQ14]
			o_low_limit <= LOW_LIMIT_POR; // [RQ14] [RQ19]
		end else begin
			o_mode <= i_thermostat_sel ? MODE_THERMOSTAT : MODE_LATCHED;
			if (i_cmd_wr) begin
				o_cmd_ptr <= i_wr_data;
			end
			if (i_high_wr) begin
				o_high_limit <= i_wr_data;
			end
			if (i_low_wr) begin
				o_low_limit <= i_wr_data;
			end
		end
	end

	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_srst);

	sequence over_raised;
		i_events.over_limit && !thermo;
	endsequence

	sequence flag_held_to_read;
		(!i_status_rd_done && !thermo) [*2];
	endsequence

	AST_BUSY_TRACKS: assert property ( // [RQ1]
		i_status_rd_start |=> o_status.busy == $past(live_busy))
		else $error("busy bit not captured from converter state");
	AST_RESERVED_ZERO: assert property ( // [RQ2]
		o_status.reserved_hi == 2'h0 && o_status.reserved_lo == 2'h0)
		else $error("reserved status bits not zero");
	AST_OVER_SETS: assert property ( // [RQ3]
		over_raised |=> over_flag)
		else $error("over-limit event did not set flag");
	AST_THERMO_MIRROR: assert property ( // [RQ4]
		thermo && i_status_rd_start |=> o_status.over_limit_flag == $past(i_alert_pin_level))
		else $error("thermostat bit 4 not mirroring alert pin");
	AST_UNDER_ZERO: assert property ( // [RQ5]
		thermo && i_status_rd_start |=> !o_status.under_limit_flag)
		else $error("under-limit bit set in thermostat mode");
	AST_FAULT_SETS: assert property ( // [RQ6]
		i_events.sensor_fault |=> fault_flag)
		else $error("sensor fault did not set flag");
	AST_FLAG_STICKS: assert property ( // [RQ7]
		over_raised ##1 (!i_status_rd_done && !thermo) |=> over_flag)
		else $error("over-limit flag dropped without read");
	AST_ADDR_HELD: assert property ( // [RQ9]
		##1 $stable(o_slave_addr))
		else $error("slave address changed outside reset");
	AST_ARA_BYTE: assert property ( // [RQ17]
		o_ara_respond |-> o_ara_byte[0] && o_ara_byte[7:1] == o_slave_addr)
		else $error("alert response byte malformed");
	AST_READ_KEEPS_IRQ: assert property ( // [RQ18]
		irq_latch && i_status_rd_done && !i_ara_rd_done |=> irq_latch)
		else $error("status read cleared interrupt latch");
	AST_LOCKOUT_GATES: assert property ( // [RQ12]
		lockout_sync |=> !o_conv_enable)
		else $error("conversion enabled under supply lockout");
	AST_SET_WINS: assert property ( // [RQ20]
		i_events.sensor_fault && i_status_rd_done |=> fault_flag)
		else $error("fault lost on clearing read");
	AST_CAPTURE_STABLE: assert property ( // [RQ21]
		!i_status_rd_start |=> $stable(o_status))
		else $error("status byte changed without read start");
	AST_FLAG_SEQ: assert property ( // [RQ7]
		over_raised ##1 flag_held_to_read |=> over_flag)
		else $error("over flag not held across window");
endmodule

// ==== verification/smbus_host_model.sv ====
`timescale 1ns/100ps
module smbus_host_model (
	input wire logic i_mclk,
	input wire logic i_respond,
	input wire logic [7:0] i_reply,
	output logic o_rd_start,
	output logic o_rd_done,
	output logic o_ara_done
);
	initial begin
		o_rd_start = 1'b0;
		o_rd_done = 1'b0;
		o_ara_done = 1'b0;
	end
	// Capture edge, then a successful read that clears flags
	task automatic status_read();
		@(negedge i_mclk);
		o_rd_start = 1'b1;
		@(negedge i_mclk);
		o_rd_start = 1'b0;
		o_rd_done = 1'b1;
		@(negedge i_mclk);
		o_rd_done = 1'b0;
	endtask
	// Reply counts as successful only if someone answered
	task automatic ara_read(output logic [7:0] b);
		@(negedge i_mclk);
		b = i_respond ? i_reply : 8'hFF;
		o_ara_done = i_respond;
		@(negedge i_mclk);
		o_ara_done = 1'b0;
	endtask
endmodule

// ==== verification/thermal_status_address_por_test.sv ====
`timescale 1ns/100ps
module thermal_status_address_por_test;
	import thermal_status_pkg::*;
	logic clk = 0, srst = 1, lock = 0, conv = 0, tsel = 0, mask = 0, pin = 0;
	logic cmd_wr = 0, high_wr = 0, low_wr = 0, rs, rd, ad, rsp, irq, cen;
	logic [1:0] sa = 0, sb = 0;
	logic [7:0] wd = 0, ab, cmd, hi, lo, b;
	logic [6:0] addr;
	alarm_events_t ev = '0, e2;
	alarm_and_activity_flags_t st;
	alert_mode_t mode;
	int fail_count = 0, total_checks = 0, cycles = 0;
	logic [6:0] atab [9] = '{7'h18, 7'h19, 7'h1A, 7'h29, 7'h2A, 7'h2B, 7'h4C, 7'h4D, 7'h4E};
	logic [2:0] mf;
	logic m_irq;
	logic [7:0] m_w [3];
	logic [6:0] m_addr;
	thermal_status_address_por dut_u (.i_mclk(clk), .i_srst(srst), .i_addr_strap_a(sa),
		.i_addr_strap_b(sb), .i_supply_lockout(lock), .i_conv_active(conv), .i_events(ev),
		.i_thermostat_sel(tsel), .i_alert_mask(mask), .i_alert_pin_level(pin),
		.i_status_rd_start(rs), .i_status_rd_done(rd), .i_ara_rd_done(ad), .i_cmd_wr(cmd_wr),
		.i_high_wr(high_wr), .i_low_wr(low_wr), .i_wr_data(wd), .o_status(st),
		.o_slave_addr(addr), .o_ara_respond(rsp), .o_ara_byte(ab), .o_irq_pending(irq),
		.o_conv_enable(cen), .o_mode(mode), .o_cmd_ptr(cmd), .o_high_limit(hi),
		.o_low_limit(lo));
	smbus_host_model host_u (.i_mclk(clk), .i_respond(rsp), .i_reply(ab), .o_rd_start(rs),
		.o_rd_done(rd), .o_ara_done(ad));
	initial begin
		forever #50 clk = ~clk;
	end
	task automatic cyc(int n = 1);
		repeat (n) @(negedge clk);
	endtask
	task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
		total_checks++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Straps held stable across the whole reset so the sync chain settles
	task automatic por(int k);
		sa = 2'(k / 3);
		sb = 2'(k % 3);
		srst = 1;
		cyc(4);
		srst = 0;
		m_addr = atab[k];
		mf = 0;
		m_irq = 0;
		cyc();
		chk("addr", 8'(m_addr), 8'(addr));
		chk("cmd", 8'h01, cmd);
		chk("high", 8'h7F, hi);
		chk("low", 8'hC9, lo);
		chk("irq_mode", 8'h00, 8'({irq, mode}));
		chk("status", 8'h00, st);
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			summarize();
		end
	end
	initial begin
		void'($urandom(65511));
		for (int k = 0; k < 9; k++) begin
			por(k);
		end
		sa = 0;
		sb = 0;
		cyc(3);
		chk("addr_held", 8'h4E, 8'(addr));
		// Host access only after release
		repeat (10) begin
			mask = 1'($urandom);
			conv = 1'($urandom);
			ev = 3'($urandom);
			e2 = 3'($urandom);
			mf |= ev;
			m_irq |= (ev != 0) && !mask;
			cyc();
			ev = '0;
			// Idle cycle so raised flags sit unread before the capture
			cyc();
			fork
				host_u.status_read();
				begin
					cyc(2);
					ev = e2;
					cyc();
					ev = '0;
				end
			join
			chk("status", {conv, 2'b00, mf, 2'b00}, st);
			mf = e2;
			m_irq |= (e2 != 0) && !mask;
			chk("irq", 8'(m_irq), 8'(irq));
			if (m_irq) begin
				host_u.ara_read(b);
				chk("ara", {m_addr, 1'b1}, b);
				m_irq = 0;
				chk("irq_clr", 8'h00, 8'(irq));
				chk("ara_off", 8'h00, 8'(rsp));
			end
		end
		mask = 0;
		tsel = 1;
		conv = 0;
		cyc();
		chk("mode", 8'(MODE_THERMOSTAT), 8'(mode));
		for (int p = 0; p < 2; p++) begin
			pin = 1'(p);
			ev = 3'b111;
			cyc();
			ev = '0;
			host_u.status_read();
			chk("therm", {3'b000, 1'(p), 4'b0100}, st);
		end
		tsel = 0;
		lock = 1;
		conv = 1;
		cyc(3);
		chk("conv_en", 8'h00, 8'(cen));
		host_u.status_read();
		chk("busy_locked", 8'h00, st);
		lock = 0;
		cyc(3);
		chk("conv_en", 8'h01, 8'(cen));
		for (int w = 0; w < 3; w++) begin
			wd = 8'($urandom);
			m_w[w] = wd;
			{cmd_wr, high_wr, low_wr} = 3'b100 >> w;
			cyc();
			{cmd_wr, high_wr, low_wr} = 3'b000;
		end
		cyc();
		chk("cmd_wr", m_w[0], cmd);
		chk("high_wr", m_w[1], hi);
		chk("low_wr", m_w[2], lo);
		// Pending state must not survive a mid-run collapse
		ev = 3'b111;
		cyc();
		ev = '0;
		por(4);
		summarize();
	end
endmodule
